//--- src/fspc_config_regs.sv
// fifo sync selection, power and pad control, coarse gain and synthesizer
// divider registers; written and read by the serial configuration port
// assumes reg_* strobes come from logic on sys_clk, the other inputs are pins
`timescale 1ns/1ps
module fspc_config_regs
   import fspc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic transmit_gate_input,
   input wire logic sync_pin,
   input wire logic input_bus_a_msb,
   input wire logic input_bus_b_msb,
   input wire logic software_sync_bit,
   output logic fifo_sync_pulse,
   output logic [3:0] fifo_out_pos,
   output logic a_sample_flag,
   output logic chan_a_sleep,
   output logic chan_b_sleep,
   output logic synth_sleep,
   output logic synth_enable,
   output logic pad_threshold_select,
   output logic bias_lpf_on_a,
   output logic bias_lpf_on_b,
   output logic [3:0] coarse_gain_a,
   output logic [3:0] coarse_gain_b,
   output logic [5:0] synth_m_value,
   output logic [3:0] synth_n_value,
   output logic synth_div_valid
);

   // ==========================================================
   // register storage
   logic [7:0] sync_src_q, ptr_preset_q, power_pad_q, coarse_gain_q, synth_div_q;
   logic wr_sync_src, wr_ptr_preset, wr_power_pad, wr_coarse_gain, wr_synth_div;
   logic [2:0] fifo_sel, wr_fifo_sel;

   assign wr_sync_src = clk_en && reg_wr_en && (reg_addr == FSPC_OFS_SYNC_SRC);
   assign wr_ptr_preset = clk_en && reg_wr_en && (reg_addr == FSPC_OFS_PTR_PRESET);
   assign wr_power_pad = clk_en && reg_wr_en && (reg_addr == FSPC_OFS_POWER_PAD);
   assign wr_coarse_gain = clk_en && reg_wr_en && (reg_addr == FSPC_OFS_COARSE_GAIN);
   assign wr_synth_div = clk_en && reg_wr_en && (reg_addr == FSPC_OFS_SYNTH_DIV);
   assign fifo_sel = sync_src_q[FSPC_POS_FIFO_SEL +: 3];
   assign wr_fifo_sel = reg_wdata[FSPC_POS_FIFO_SEL +: 3];

   // writable bits only; spare registers are never stored
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync_src_q <= FSPC_RST_SYNC_SRC & FSPC_MSK_SYNC_SRC;
         ptr_preset_q <= FSPC_RST_PTR_PRESET & FSPC_MSK_PTR_PRESET;
         power_pad_q <= FSPC_RST_POWER_PAD & FSPC_MSK_POWER_PAD;
         coarse_gain_q <= FSPC_RST_COARSE_GAIN & FSPC_MSK_COARSE_GAIN;
         synth_div_q <= FSPC_RST_SYNTH_DIV & FSPC_MSK_SYNTH_DIV;
      end else begin
         if (wr_sync_src) begin
            sync_src_q <= reg_wdata & FSPC_MSK_SYNC_SRC;
         end
         if (wr_ptr_preset) begin
            ptr_preset_q <= reg_wdata & FSPC_MSK_PTR_PRESET;
         end
         if (wr_power_pad) begin
            power_pad_q <= reg_wdata & FSPC_MSK_POWER_PAD;
         end
         if (wr_coarse_gain) begin
            coarse_gain_q <= reg_wdata & FSPC_MSK_COARSE_GAIN;
         end
         if (wr_synth_div) begin
            synth_div_q <= reg_wdata & FSPC_MSK_SYNTH_DIV;
         end
      end
   end

   // ==========================================================
   // read port, data one cycle after the read strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd_en) begin
         if (reg_addr == FSPC_OFS_SYNC_SRC) begin
            reg_rdata <= sync_src_q;
         end else if (reg_addr == FSPC_OFS_PTR_PRESET) begin
            reg_rdata <= ptr_preset_q;
         end else if (reg_addr == FSPC_OFS_POWER_PAD) begin
            reg_rdata <= power_pad_q;
         end else if (reg_addr == FSPC_OFS_COARSE_GAIN) begin
            reg_rdata <= coarse_gain_q;
         end else if (reg_addr == FSPC_OFS_SYNTH_DIV) begin
            reg_rdata <= synth_div_q;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ==========================================================
   // pin synchronisers
   logic [3:0] pin_meta_q, pin_sync_q;
   logic tx_s, sync_s, a_msb_s, b_msb_s;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_meta_q <= 4'h0;
         pin_sync_q <= 4'h0;
      end else if (clk_en) begin
         pin_meta_q <= {input_bus_b_msb, input_bus_a_msb, sync_pin, transmit_gate_input};
         pin_sync_q <= pin_meta_q;
      end
   end

   assign tx_s = pin_sync_q[0];
   assign sync_s = pin_sync_q[1];
   assign a_msb_s = pin_sync_q[2];
   assign b_msb_s = pin_sync_q[3];

   // ==========================================================
   // fifo sync source selection
   logic a_msb_prev_q, b_msb_prev_q, tx_prev_q, armed_q, sync_level_prev_q;
   logic sync_level, sync_evt, edge_src;

   assign edge_src = (fifo_sel == FSPC_SRC_EDGE_A) || (fifo_sel == FSPC_SRC_EDGE_B);

   always_comb begin
      case (fifo_sel)
         FSPC_SRC_TX_PIN: sync_level = tx_s;
         FSPC_SRC_SYNC_PIN: sync_level = sync_s;
         FSPC_SRC_SOFTWARE: sync_level = software_sync_bit;
         FSPC_SRC_EDGE_A: sync_level = armed_q && (a_msb_s != a_msb_prev_q);
         FSPC_SRC_EDGE_B: sync_level = armed_q && (b_msb_s != b_msb_prev_q);
         FSPC_SRC_ONE: sync_level = 1'b1;
         default: sync_level = 1'b0;
      endcase
   end

   // an event is the rise of the selected level
   assign sync_evt = sync_level && !sync_level_prev_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a_msb_prev_q <= 1'b0;
         b_msb_prev_q <= 1'b0;
         tx_prev_q <= 1'b0;
         sync_level_prev_q <= 1'b0;
      end else if (clk_en) begin
         a_msb_prev_q <= a_msb_s;
         b_msb_prev_q <= b_msb_s;
         tx_prev_q <= tx_s;
         sync_level_prev_q <= sync_level;
      end
   end

   // one edge sync per arming; rearmed by reset or a new source value
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         armed_q <= 1'b1;
      end else if (clk_en) begin
         if (wr_sync_src && (wr_fifo_sel != fifo_sel)) begin
            armed_q <= 1'b1;
         end else if (sync_evt && edge_src) begin
            armed_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // fifo output position counter
   logic [3:0] out_pos_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         out_pos_q <= FSPC_RST_OUT_POS;
         fifo_sync_pulse <= 1'b0;
      end else if (clk_en) begin
         fifo_sync_pulse <= sync_evt;
         if (sync_evt) begin
            out_pos_q <= ptr_preset_q[FSPC_POS_SYNC_START +: 4];
         end else begin
            out_pos_q <= out_pos_q + 4'h1;
         end
      end
   end

   assign fifo_out_pos = out_pos_q;

   // ==========================================================
   // a sample identification
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a_sample_flag <= 1'b0;
      end else if (clk_en) begin
         if (sync_src_q[FSPC_POS_AFLAG_SEL]) begin
            a_sample_flag <= b_msb_s;
         end else begin
            a_sample_flag <= tx_s && !tx_prev_q;
         end
      end
   end

   // ==========================================================
   // power, pad and gain controls from register bits; channel b also sleeps while channel a sleeps
   assign chan_b_sleep = power_pad_q[FSPC_POS_SLEEP_B]
      || power_pad_q[FSPC_POS_SLEEP_A];
   assign chan_a_sleep = power_pad_q[FSPC_POS_SLEEP_A];
   assign synth_sleep = power_pad_q[FSPC_POS_SYNTH_SLEEP];
   assign synth_enable = power_pad_q[FSPC_POS_SYNTH_ENA];
   assign pad_threshold_select = power_pad_q[FSPC_POS_PAD_LEVEL];
   assign bias_lpf_on_a = !power_pad_q[FSPC_POS_LPF_OFF_A];
   assign bias_lpf_on_b = !power_pad_q[FSPC_POS_LPF_OFF_B];
   assign coarse_gain_a = coarse_gain_q[FSPC_POS_GAIN_A +: 4];
   assign coarse_gain_b = coarse_gain_q[FSPC_POS_GAIN_B +: 4];

   // ==========================================================
   // synthesizer dividers
   logic [5:0] m_dec;
   logic [3:0] n_dec;
   logic m_ok, n_ok;

   fspc_therm_decode #(.W(5)) u_m_decode (
      .code(synth_div_q[FSPC_POS_DIV_M +: 5]),
      .value(m_dec),
      .valid(m_ok)
   );

   fspc_therm_decode #(.W(3)) u_n_decode (
      .code(synth_div_q[FSPC_POS_DIV_N +: 3]),
      .value(n_dec),
      .valid(n_ok)
   );

   // output clock = reference * m / n, applied by the analog synthesizer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         synth_m_value <= 6'h01;
         synth_n_value <= 4'h1;
         synth_div_valid <= 1'b1;
      end else if (clk_en) begin
         synth_m_value <= m_dec;
         synth_n_value <= n_dec;
         synth_div_valid <= m_ok && n_ok;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_sync_edge_armed: assert property (clk_en && edge_src && !armed_q
      |=> !fifo_sync_pulse)
      else $error("edge sync taken while not armed");
   a_sync_edge_once: assert property (clk_en && sync_evt && edge_src && !wr_sync_src
      |=> !armed_q)
      else $error("edge sync source stayed armed");
   a_src_constants: assert property ((fifo_sel == FSPC_SRC_ONE) |-> sync_level)
      else $error("constant one source not high");
   a_src_zero: assert property (fifo_sel == FSPC_SRC_ZERO_A
      || fifo_sel == FSPC_SRC_ZERO_B |-> !sync_level)
      else $error("constant zero source not low");
   a_preset_load: assert property (clk_en && sync_evt |=> fifo_sync_pulse
      && out_pos_q == $past(ptr_preset_q[7:4]))
      else $error("preset not loaded on sync");
   a_sleep_force_b: assert property (chan_a_sleep |-> chan_b_sleep)
      else $error("channel b awake while a sleeps");
   a_power_write: assert property (wr_power_pad
      |=> pad_threshold_select == $past(reg_wdata[7])
      && synth_enable == $past(reg_wdata[0]) && synth_sleep == $past(reg_wdata[1]))
      else $error("power register write not applied");
   a_bias_lpf_sense: assert property (wr_power_pad
      |=> bias_lpf_on_a == !$past(reg_wdata[3]) && bias_lpf_on_b == !$past(reg_wdata[2]))
      else $error("bias filter sense wrong");
   a_gain_write: assert property (wr_coarse_gain
      |=> coarse_gain_a == $past(reg_wdata[7:4]) && coarse_gain_b == $past(reg_wdata[3:0]))
      else $error("coarse gain write not applied");
   a_m_decode: assert property (wr_synth_div && reg_wdata[7:3] == 5'h07 ##1 clk_en
      |=> synth_m_value == 6'h08)
      else $error("m divider decode wrong");
   a_n_decode: assert property (synth_div_q[2:0] == 3'h2 && clk_en
      |=> !synth_div_valid)
      else $error("invalid n code reported valid");
   a_spare_read: assert property (clk_en && reg_rd_en && reg_addr == FSPC_OFS_SPARE_A
      |=> reg_rdata == 8'h00)
      else $error("spare register read nonzero");
   a_aflag_edge: assert property (clk_en && !sync_src_q[2] && tx_s && !tx_prev_q
      |=> a_sample_flag)
      else $error("a sample flag missed enable rise");

   c_edge_sync: cover property (clk_en && sync_evt && edge_src);
   c_pin_sync: cover property (clk_en && sync_evt && fifo_sel == FSPC_SRC_SYNC_PIN);
   c_div_write: cover property (wr_synth_div ##2 synth_div_valid && synth_m_value == 6'h20);
   c_chan_a_sleep: cover property (chan_a_sleep);

endmodule

//--- src/fspc_pkg.sv
// constants for the fifo sync, power and synthesizer divider register slice
// assumes byte registers written by the serial configuration port on sys_clk
package fspc_pkg;

   // ==========================================================
   // register offsets
   localparam logic [4:0] FSPC_OFS_SYNC_SRC = 5'h17;
   localparam logic [4:0] FSPC_OFS_PTR_PRESET = 5'h18;
   localparam logic [4:0] FSPC_OFS_SPARE_A = 5'h19;
   localparam logic [4:0] FSPC_OFS_POWER_PAD = 5'h1A;
   localparam logic [4:0] FSPC_OFS_COARSE_GAIN = 5'h1B;
   localparam logic [4:0] FSPC_OFS_SPARE_B = 5'h1C;
   localparam logic [4:0] FSPC_OFS_SYNTH_DIV = 5'h1D;

   // ==========================================================
   // values after reset and writable bit masks
   localparam logic [7:0] FSPC_RST_SYNC_SRC = 8'h15;
   localparam logic [7:0] FSPC_RST_PTR_PRESET = 8'h80;
   localparam logic [7:0] FSPC_RST_POWER_PAD = 8'h0D;
   localparam logic [7:0] FSPC_RST_COARSE_GAIN = 8'hFF;
   localparam logic [7:0] FSPC_RST_SYNTH_DIV = 8'h00;
   localparam logic [7:0] FSPC_MSK_SYNC_SRC = 8'h3C;
   localparam logic [7:0] FSPC_MSK_PTR_PRESET = 8'hF0;
   localparam logic [7:0] FSPC_MSK_POWER_PAD = 8'hBF;
   localparam logic [7:0] FSPC_MSK_COARSE_GAIN = 8'hFF;
   localparam logic [7:0] FSPC_MSK_SYNTH_DIV = 8'hFF;

   // ==========================================================
   // field positions
   localparam int FSPC_POS_FIFO_SEL = 3;
   localparam int FSPC_POS_AFLAG_SEL = 2;
   localparam int FSPC_POS_SYNC_START = 4;
   localparam int FSPC_POS_PAD_LEVEL = 7;
   localparam int FSPC_POS_SLEEP_B = 5;
   localparam int FSPC_POS_SLEEP_A = 4;
   localparam int FSPC_POS_LPF_OFF_A = 3;
   localparam int FSPC_POS_LPF_OFF_B = 2;
   localparam int FSPC_POS_SYNTH_SLEEP = 1;
   localparam int FSPC_POS_SYNTH_ENA = 0;
   localparam int FSPC_POS_GAIN_A = 4;
   localparam int FSPC_POS_GAIN_B = 0;
   localparam int FSPC_POS_DIV_M = 3;
   localparam int FSPC_POS_DIV_N = 0;

   // ==========================================================
   // fifo sync source codes
   localparam logic [2:0] FSPC_SRC_TX_PIN = 3'h0;
   localparam logic [2:0] FSPC_SRC_SYNC_PIN = 3'h1;
   localparam logic [2:0] FSPC_SRC_SOFTWARE = 3'h2;
   localparam logic [2:0] FSPC_SRC_ZERO_A = 3'h3;
   localparam logic [2:0] FSPC_SRC_EDGE_A = 3'h4;
   localparam logic [2:0] FSPC_SRC_EDGE_B = 3'h5;
   localparam logic [2:0] FSPC_SRC_ZERO_B = 3'h6;
   localparam logic [2:0] FSPC_SRC_ONE = 3'h7;

   localparam logic [3:0] FSPC_RST_OUT_POS = 4'h0;

endpackage

//--- src/fspc_therm_decode.sv
// thermometer coded divider decoder: 0..0 -> 1, 0..01 -> 2, ..., 1..1 -> 2^w
// assumes a static code from a register; output is combinational
`timescale 1ns/1ps
module fspc_therm_decode #(
   parameter int W = 3
) (
   input wire logic [W-1:0] code,
   output logic [W:0] value,
   output logic valid
);

   logic [W:0] pattern;

   always_comb begin
      value = '0;
      valid = 1'b0;
      pattern = '0;
      for (int k = 0; k <= W; k++) begin
         pattern = ((W+1)'(1) << k) - (W+1)'(1);
         if ({1'b0, code} == pattern) begin
            value = (W+1)'(1) << k;
            valid = 1'b1;
         end
      end
   end

endmodule

//--- verif/fspc_host_model.sv
// host model for the configuration slice: issues single-byte register accesses
// assumes sys_clk from the bench; strobes change on the falling edge only
`timescale 1ns/1ps
module fspc_host_model (
   input wire logic sys_clk,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
   end

   // =====
   // one access: strobe held across exactly one rising edge
   // divider codes go out as asked; no fast reference is modelled
   task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      reg_wr_en = wr;
      reg_rd_en = ~wr;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      // released bus shows no stale value
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the fifo sync, power and divider register slice
// assumes the host model drives the strobes; pins are driven from here
`timescale 1ns/1ps
module tb_top;
   import fspc_pkg::*;
   logic sys_clk, rst, clk_en, reg_wr_en, reg_rd_en, rd_q;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, pw, gn;
   logic transmit_gate_input, sync_pin, input_bus_a_msb, input_bus_b_msb, software_sync_bit;
   logic fifo_sync_pulse, a_sample_flag, chan_a_sleep, chan_b_sleep, synth_sleep;
   logic synth_enable, pad_threshold_select, bias_lpf_on_a, bias_lpf_on_b, synth_div_valid;
   logic [3:0] fifo_out_pos, coarse_gain_a, coarse_gain_b, synth_n_value, exp_pos;
   logic [5:0] synth_m_value;
   logic [7:0] exp_q [$];
   logic [31:0] seed = 32'h29;
   int failures = 0;
   int samples_checked = 0;
   int pulses = 0;
   int aflags = 0;
   int m, n;
   logic [4:0] adr [8] = '{5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h00};
   logic [7:0] rstv [8] = '{8'h14, 8'h80, 8'h00, 8'h0D, 8'hFF, 8'h00, 8'h00, 8'h00};
   logic [7:0] wv [8] = '{8'hE7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] bkv [8] = '{8'h24, 8'hF0, 8'h00, 8'hBF, 8'hFF, 8'h00, 8'hFF, 8'h00};

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   fspc_host_model i_fspc_host_model (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   fspc_config_regs i_fspc_config_regs (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .transmit_gate_input(transmit_gate_input), .sync_pin(sync_pin),
      .input_bus_a_msb(input_bus_a_msb), .input_bus_b_msb(input_bus_b_msb),
      .software_sync_bit(software_sync_bit), .fifo_sync_pulse(fifo_sync_pulse),
      .fifo_out_pos(fifo_out_pos), .a_sample_flag(a_sample_flag),
      .chan_a_sleep(chan_a_sleep), .chan_b_sleep(chan_b_sleep), .synth_sleep(synth_sleep),
      .synth_enable(synth_enable), .pad_threshold_select(pad_threshold_select),
      .bias_lpf_on_a(bias_lpf_on_a), .bias_lpf_on_b(bias_lpf_on_b),
      .coarse_gain_a(coarse_gain_a), .coarse_gain_b(coarse_gain_b),
      .synth_m_value(synth_m_value), .synth_n_value(synth_n_value),
      .synth_div_valid(synth_div_valid));

   // =====
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int therm(input int code, input int w);
      for (int k = 0; k <= w; k++) begin
         if (code == (1 << k) - 1) begin
            return 1 << k;
         end
      end
      return 0;
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      i_fspc_host_model.access(1'b1, a, d);
   endtask

   task automatic rd_exp(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_fspc_host_model.access(1'b0, a, 8'h00);
   endtask

   task automatic chk_ctl(input logic [7:0] p, input logic [7:0] g);
      @(negedge sys_clk);
      check("sleep_a", 8'(chan_a_sleep), 8'(p[4]));
      check("sleep_b", 8'(chan_b_sleep), 8'(p[5] | p[4]));
      check("synth_sleep", 8'(synth_sleep), 8'(p[1]));
      check("synth_ena", 8'(synth_enable), 8'(p[0]));
      check("pad_sel", 8'(pad_threshold_select), 8'(p[7]));
      check("lpf_a", 8'(bias_lpf_on_a), 8'(!p[3]));
      check("lpf_b", 8'(bias_lpf_on_b), 8'(!p[2]));
      check("gain", {coarse_gain_a, coarse_gain_b}, g);
   endtask

   task automatic drive_src(input int s, input logic v);
      repeat (5) @(negedge sys_clk);
      case (s)
         0: transmit_gate_input = v;
         1: sync_pin = v;
         2: software_sync_bit = v;
         4: input_bus_a_msb = v;
         5: input_bus_b_msb = v;
         default: ;
      endcase
      repeat (8) @(negedge sys_clk);
   endtask

   // =====
   // result watcher: read data half a cycle after the read edge, sync pulses
   always @(posedge sys_clk) begin
      rd_q <= reg_rd_en & clk_en;
   end

   always @(negedge sys_clk) begin
      if (rd_q === 1'b1 && exp_q.size() > 0) begin
         check("rdata", reg_rdata, exp_q.pop_front());
      end
      if (fifo_sync_pulse === 1'b1) begin
         pulses++;
         check("out_pos", 8'(fifo_out_pos), 8'(exp_pos));
      end
      if (a_sample_flag === 1'b1) begin
         aflags++;
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      tally_and_finish();
   end

   // =====
   // main sequence
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      transmit_gate_input = 1'b0;
      sync_pin = 1'b0;
      input_bus_a_msb = 1'b0;
      input_bus_b_msb = 1'b0;
      software_sync_bit = 1'b0;
      exp_pos = 4'h8;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      chk_ctl(8'h0D, 8'hFF);
      check("m_rst", {synth_div_valid, 1'b0, synth_m_value}, 8'h81);
      for (int i = 0; i < 8; i++) begin
         rd_exp(adr[i], rstv[i]);
      end
      for (int i = 0; i < 8; i++) begin
         wr(adr[i], wv[i]);
         rd_exp(adr[i], bkv[i]);
      end
      for (int i = 0; i < 16; i++) begin
         pw = 8'(rnd());
         gn = 8'(rnd());
         wr(5'h1A, pw);
         wr(5'h1B, gn);
         chk_ctl(pw, gn);
         rd_exp(5'h1A, pw & 8'hBF);
      end
      clk_en = 1'b0;
      wr(5'h1B, ~gn);
      clk_en = 1'b1;
      rd_exp(5'h1B, gn);
      for (int c = 0; c < 256; c++) begin
         wr(5'h1D, 8'(c));
         repeat (3) @(negedge sys_clk);
         m = therm(c >> 3, 5);
         n = therm(c & 7, 3);
         check("m_value", 8'(synth_m_value), 8'(m));
         check("n_value", 8'(synth_n_value), 8'(n));
         check("div_ok", 8'(synth_div_valid), 8'(m != 0 && n != 0));
      end
      wr(5'h18, 8'hA5);
      exp_pos = 4'hA;
      for (int s = 0; s < 8; s++) begin
         drive_src(s - 1, 1'b0);
         pulses = 0;
         wr(5'h17, 8'(s << 3));
         drive_src(s, 1'b1);
         check("sync_cnt", 8'(pulses), (s == 3 || s == 6) ? 8'h00 : 8'h01);
         if (s == 4 || s == 5) begin
            pulses = 0;
            wr(5'h17, 8'(s << 3));
            drive_src(s, 1'b0);
            drive_src(s, 1'b1);
            check("sync_once", 8'(pulses), 8'h00);
            wr(5'h17, 8'h00);
            wr(5'h17, 8'(s << 3));
            drive_src(s, 1'b0);
            drive_src(s, 1'b1);
            check("sync_rearm", 8'(pulses), 8'h01);
         end
      end
      wr(5'h17, 8'h1C);
      drive_src(5, 1'b1);
      check("aflag_hi", 8'(a_sample_flag), 8'h01);
      drive_src(5, 1'b0);
      check("aflag_lo", 8'(a_sample_flag), 8'h00);
      wr(5'h17, 8'h18);
      aflags = 0;
      drive_src(0, 1'b1);
      check("aflag_rise", 8'(aflags), 8'h01);
      tally_and_finish();
   end
endmodule
